// ---- src/smc_defs.vh ----
// Purpose: constants for the standby mode control block
// Assumes: included by bare name
// Notes: register sits at offset 0 of a plain strobe port
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH
`define SMC_ADDR_W 4
`define SMC_OFF_STANDBY_CONTROL 4'h0
`define SMC_OFF_POWER_STATUS 4'h1
`define SMC_BIT_DEEP_SEL 7
`define SMC_BIT_HOLD_EN 6
`define SMC_BIT_RSVD5 5
`define SMC_BIT_RSVD4 4
`define SMC_BIT_TSEL_MSB 3
`define SMC_RST_DEEP_SEL 1'b0
`define SMC_RST_HOLD_EN 1'b1
`define SMC_RST_TSEL 4'hF
`define SMC_RST_TSEL_MSB 1'b1
`define SMC_ST_RUN 2'h0
`define SMC_ST_SLEEP 2'h1
`define SMC_ST_STANDBY 2'h2
`define SMC_ST_WAKE 2'h3
`endif

// ---- src/smc_wake_timer.v ----
// Purpose: clock stabilisation wait counter for wake from deep standby
// Assumes: start is a one-cycle pulse, tsel stable while counting
// Notes: state count is 2^(tsel+4) for codes 0101..1111, shortened by SHIFT
`timescale 1ns/100ps
module smc_wake_timer #(
	parameter SHIFT = 0
) (
	input wire clk, // System clock
	input wire rst_n, // Synchronous reset, active low
	input wire start, // Begin a wait
	input wire [3:0] tsel, // Timer select code
	output reg busy_r, // Counting
	output reg done_r // One-cycle end of wait
);
	reg [19:0] cnt_r;
	reg [19:0] load;
	reg [4:0] sh;

	always @*
	begin
		sh = {1'b0, tsel} + 5'h4;
		if (sh > SHIFT[4:0] + 5'h1)
			sh = sh - SHIFT[4:0];
		else
			sh = 5'h1;
		load = (20'h1 << sh) - 20'h1;
	end

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_r <= 20'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			if (start)
			begin
				cnt_r <= load;
				busy_r <= 1'b1;
			end
			else if (busy_r)
			begin
				if (cnt_r == 20'h0)
				begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
				else
					cnt_r <= cnt_r - 20'h1;
			end
		end
	end
endmodule // smc_wake_timer

// ---- src/smc_standby_ctrl.v ----
// Purpose: standby control register and low-power state selection
// Assumes: sleep request and wake events come from logic on SYS_CLK
// Notes: bus outputs are passed through, held or released in deep standby
`timescale 1ns/100ps
`include "smc_defs.vh"
module smc_standby_ctrl #(
	parameter BUS_W = 32,
	parameter WAIT_SHIFT = 0
) (
	input wire SYS_CLK, // System clock 100 MHz
	input wire RST_N, // Synchronous reset, active low
	input wire [`SMC_ADDR_W-1:0] ADDR, // Register address
	input wire [7:0] WDATA, // Write data
	input wire WR, // Write strobe
	input wire RD, // Read strobe
	output reg [7:0] RDATA, // Read data, cycle after RD
	input wire [2:0] TSEL_LOW, // Lower three timer select bits
	input wire SLEEP_EXEC, // Sleep instruction executed, pulse
	input wire EXT_WAKE, // External interrupt wake, pulse
	input wire ANY_WAKE, // Any interrupt that ends sleep, pulse
	input wire [BUS_W-1:0] BUS_OUT, // Address and control values from core
	input wire [BUS_W-1:0] BUS_OE, // Their enables from core
	output reg [BUS_W-1:0] PIN_OUT, // Values to pins
	output reg [BUS_W-1:0] PIN_OE, // Enables to pins, high drives
	output reg SLEEPING, // In sleep mode
	output reg DEEP_STANDBY, // In deep standby or stabilisation wait
	output reg CLK_STOP // Oscillator stop request
);
	reg deep_sel_r;
	reg hold_en_r;
	reg tsel_msb_r;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	wire wait_busy;
	wire wait_done;
	wire start_wait;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			deep_sel_r <= `SMC_RST_DEEP_SEL;
			hold_en_r <= `SMC_RST_HOLD_EN;
			tsel_msb_r <= `SMC_RST_TSEL_MSB;
		end
		else if (WR && ADDR == `SMC_OFF_STANDBY_CONTROL)
		begin
			deep_sel_r <= WDATA[`SMC_BIT_DEEP_SEL];
			hold_en_r <= WDATA[`SMC_BIT_HOLD_EN];
			tsel_msb_r <= WDATA[`SMC_BIT_TSEL_MSB];
		end
		// No hardware clear of deep_sel_r on wake
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always @(posedge SYS_CLK)
	begin
		if (!RST_N)
			RDATA <= 8'h00;
		else if (RD)
		begin
			RDATA <= 8'h00;
			if (ADDR == `SMC_OFF_STANDBY_CONTROL)
			begin
				RDATA[`SMC_BIT_DEEP_SEL] <= deep_sel_r;
				RDATA[`SMC_BIT_HOLD_EN] <= hold_en_r;
				RDATA[`SMC_BIT_RSVD5] <= 1'b0;
				RDATA[`SMC_BIT_RSVD4] <= 1'b0;
				RDATA[`SMC_BIT_TSEL_MSB] <= tsel_msb_r;
				RDATA[2:0] <= TSEL_LOW;
			end
			else if (ADDR == `SMC_OFF_POWER_STATUS)
				RDATA[1:0] <= state_r;
		end
	end

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	assign start_wait = (state_r == `SMC_ST_STANDBY) && EXT_WAKE;

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
		`SMC_ST_RUN:
			if (SLEEP_EXEC)
				state_nxt = deep_sel_r ? `SMC_ST_STANDBY : `SMC_ST_SLEEP;
		`SMC_ST_SLEEP:
			if (ANY_WAKE)
				state_nxt = `SMC_ST_RUN;
		`SMC_ST_STANDBY:
			if (EXT_WAKE)
				state_nxt = `SMC_ST_WAKE;
		`SMC_ST_WAKE:
			if (wait_done)
				state_nxt = `SMC_ST_RUN;
		default:
			state_nxt = `SMC_ST_RUN;
		endcase
	end

	always @(posedge SYS_CLK)
	begin
		if (!RST_N)
			state_r <= `SMC_ST_RUN;
		else
			state_r <= state_nxt;
	end

	smc_wake_timer #(
		.SHIFT(WAIT_SHIFT)
	) u_timer (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.start(start_wait),
		.tsel({tsel_msb_r, TSEL_LOW}),
		.busy_r(wait_busy),
		.done_r(wait_done)
	);

	// ----------------------------------------
	// Pin control and status outputs
	// ----------------------------------------
	always @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			PIN_OUT <= {BUS_W{1'b0}};
			PIN_OE <= {BUS_W{1'b0}};
			SLEEPING <= 1'b0;
			DEEP_STANDBY <= 1'b0;
			CLK_STOP <= 1'b0;
		end
		else
		begin
			SLEEPING <= (state_nxt == `SMC_ST_SLEEP);
			DEEP_STANDBY <= (state_nxt == `SMC_ST_STANDBY) || (state_nxt == `SMC_ST_WAKE);
			CLK_STOP <= (state_nxt == `SMC_ST_STANDBY);
			if (state_nxt == `SMC_ST_STANDBY || state_nxt == `SMC_ST_WAKE)
			begin
				if (!hold_en_r)
					PIN_OE <= {BUS_W{1'b0}};
				// Otherwise values and enables stay frozen
			end
			else
			begin
				PIN_OUT <= BUS_OUT;
				PIN_OE <= BUS_OE;
			end
		end
	end
endmodule // smc_standby_ctrl

// ---- tb/smc_standby_ctrl_assertions.sv ----
// Purpose: standby control checks
// Assumes: bench keeps bit 3 set
// Notes: m_r mirrors bits 7, 6, 3
`timescale 1ns/100ps
module smc_chk #(parameter BUS_W = 32) (
	input SYS_CLK, // Clock
	input RST_N, // Reset
	input [3:0] ADDR, // Address
	input [7:0] WDATA, // Data
	input WR, // Write
	input RD, // Read
	input [7:0] RDATA, // Data
	input SLEEP_EXEC, // Sleep
	input EXT_WAKE, // Wake
	input [BUS_W-1:0] PIN_OE, // Enables
	input SLEEPING, // Mode
	input DEEP_STANDBY // Mode
);
	reg [2:0] m_r;
	always @(posedge SYS_CLK)
		if (!RST_N)
			m_r <= 3'h3;
		else if (WR && ADDR == 4'h0)
			m_r <= {WDATA[7:6], WDATA[3]};
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	sel_mode_a: assert property (SLEEP_EXEC && !SLEEPING && !DEEP_STANDBY |=>
		DEEP_STANDBY == $past(m_r[2]) && SLEEPING != $past(m_r[2])) else $error("mode");
	deep_sel_a: assert property (DEEP_STANDBY |-> m_r[2]) else $error("sel");
	one_mode_a: assert property (!(SLEEPING && DEEP_STANDBY)) else $error("both");
	read_back_a: assert property (RD && ADDR == 4'h0 |=>
		{RDATA[7:6], RDATA[3]} == $past(m_r)) else $error("read");
	rsvd_bits_a: assert property (RD |=> RDATA[5:4] == 2'h0) else $error("rsvd");
	float_pins_a: assert property (DEEP_STANDBY && $past(DEEP_STANDBY) && !m_r[1] |->
		PIN_OE == '0) else $error("float");
	hold_pins_a: assert property (DEEP_STANDBY && $past(DEEP_STANDBY) && m_r[1] |->
		$stable(PIN_OE)) else $error("hold");
	wake_wait_a: assert property (DEEP_STANDBY && EXT_WAKE |=>
		DEEP_STANDBY[*8] ##[20:40] !DEEP_STANDBY) else $error("wait");
endmodule // smc_chk
bind smc_standby_ctrl smc_chk #(.BUS_W(BUS_W)) smc_chk_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP_EXEC(SLEEP_EXEC),
	.EXT_WAKE(EXT_WAKE), .PIN_OE(PIN_OE), .SLEEPING(SLEEPING), .DEEP_STANDBY(DEEP_STANDBY));

// ---- tb/tb_standby_mode_control.sv ----
// Purpose: standby control bench
// Assumes: WAIT_SHIFT 14, wake wait 32
// Notes: TSEL_LOW tied to 7
`timescale 1ns/100ps
module tb_standby_mode_control;
	reg clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0;
	reg [2:0] pul = 3'h0;
	reg [3:0] adr = 4'h0;
	reg [7:0] wd = 8'h0;
	reg [31:0] bus = 32'h0;
	wire [7:0] rdat;
	wire [31:0] oe;
	wire sl, ds, cs;
	wire [31:0] po;
	int n_mismatch = 0, checks = 0, n;
	smc_standby_ctrl #(.WAIT_SHIFT(14)) smc_standby_ctrl_inst (.SYS_CLK(clk), .RST_N(rst_n),
		.ADDR(adr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdat), .TSEL_LOW(3'h7),
		.SLEEP_EXEC(pul[2]), .EXT_WAKE(pul[1]), .ANY_WAKE(pul[0]), .BUS_OUT(bus),
		.BUS_OE(~bus), .PIN_OUT(po), .PIN_OE(oe), .SLEEPING(sl), .DEEP_STANDBY(ds), .CLK_STOP(cs));
	initial forever #5 clk = ~clk;
	always @(posedge clk) bus <= bus + 32'h1;
	task chk(input logic [31:0] s, e);
		checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Write when w is set, else read and expect d
	task acc(input w, input [3:0] a, input [7:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'h0;
		rd <= 1'h0;
		#1 if (!w) chk(rdat, d);
	endtask
	task go(input [2:0] p);
		@(posedge clk);
		pul <= p;
		@(posedge clk);
		pul <= 3'h0;
		#1;
	endtask
	task wake;
		go(3'h2);
		n = 0;
		while (ds === 1'h1 && n < 99)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk(n > 30 && n < 36, 1'h1);
		if (n == 99)
			close_out;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		acc(0, 4'h0, 8'h4F);
		acc(1, 4'h0, 8'hF8);
		acc(0, 4'h0, 8'hCF);
		acc(0, 4'h9, 8'h00);
		$display("register test done");
		chk(po, bus - 32'h1);
		acc(1, 4'h0, 8'h48);
		go(3'h4);
		chk({sl, ds}, 2'h2);
		go(3'h1);
		chk(sl, 1'h0);
		acc(1, 4'h0, 8'hC8);
		go(3'h4);
		chk({sl, ds}, 2'h1);
		chk(cs, 1'h1);
		n = po;
		acc(0, 4'h1, 8'h02);
		chk(po, n);
		wake;
		chk(cs, 1'h0);
		acc(0, 4'h0, 8'hCF);
		acc(1, 4'h0, 8'h88);
		go(3'h4);
		#20 chk(oe, 32'h0);
		wake;
		acc(1, 4'h0, 8'h48);
		acc(0, 4'h0, 8'h4F);
		$display("mode test done");
		close_out;
	end
endmodule // tb_standby_mode_control
